// *** src/avg_filter.sv ***
// Exponential averaging stage with bypass
`timescale 1ns/1ns
module avg_filter import tpp_pkg::*; #(
   parameter int W            = TEMP_W,
   parameter int SAMPLE_SHIFT = 4
) (
   input  wire logic         i_ref_clk,
   input  wire logic         i_rst_b,
   // Samples in
   input  wire logic         i_valid,
   input  wire logic [W-1:0] i_sample,
   // Averaging time in ms
   input  wire logic [15:0]  i_avg_ms,
   // Averaged samples out
   sample_if.src             out
);
   localparam int FRAC = 16;
   localparam int AW   = W + FRAC + 1;

   function automatic logic [5:0] log2ceil(input logic [15:0] v);
      logic [5:0] r;
      r = '0;
      for (int i = 0; i < 16; i++) begin
         if ((17'(1) << i) < {1'b0, v}) begin
            r = 6'(i + 1);
         end
      end
      return r;
   endfunction

   logic signed [AW-1:0] acc_q;
   wire  signed [AW-1:0] x_ext  = AW'(signed'(i_sample)) <<< FRAC;
   wire         [5:0]    shift  = log2ceil(i_avg_ms) + 6'(SAMPLE_SHIFT);
   wire  signed [AW-1:0] step   = (x_ext - acc_q) >>> shift;
   wire                  bypass = (i_avg_ms == 16'h0000);
   wire  signed [AW-1:0] acc_d  = bypass ? x_ext : acc_q + step;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         acc_q     <= '0;
         out.valid <= 1'b0;
         out.data  <= '0;
      end else begin
         out.valid <= i_valid;
         if (i_valid) begin
            acc_q    <= acc_d;
            out.data <= acc_d[FRAC +: W];
         end
      end
   end
endmodule // avg_filter

// *** src/sample_if.sv ***
// Sample stream carrier between the averaging stage and the hold stage
`timescale 1ns/1ns
interface sample_if #(parameter int W = 16);
   logic         valid;
   logic [W-1:0] data;
   modport src (output valid, output data);
   modport snk (input valid, input data);
endinterface

// *** src/temp_post_proc.sv ***
// Temperature post-processing top: APB registers, averaging and hold stage
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ns
//Contract
//- Average samples with time constant set by averaging time; zero bypasses; step 1 ms.
//- Averaging runs together with every hold mode and feeds it.
//- Five hold settings: off, peak, valley, advanced peak, advanced valley.
//- Peak hold keeps previous maximum for hold duration once input descends.
//- On expiry drop by one eighth of peak-minimum gap, hold again.
//- After second hold, decay slowly until output tracks input again.
//- Hold duration 0 to 65 s; 65 holds forever, 0 disables.
//- Valley hold mirrors peak hold with directions inverted.
//- Advanced peak accepts lower maximum only after input fell below threshold.
//- With hysteresis, peak accepted only after input fell by hysteresis amount.
//- Advanced valley accepts higher minimum only after input rose above threshold.
//- With hysteresis, minimum accepted only after input rose by hysteresis amount.
//- Hotspot detection within 90 us when averaging time is zero.
//- Both processed and averaged temperature are available.
//- Ambient source is head probe unless a fixed value is configured.
module temp_post_proc import tpp_pkg::*; #(
   parameter int W            = TEMP_W,
   parameter int TICK_CYC     = MS_TICK_CYC,
   parameter int SAMPLE_SHIFT = 4
) (
   // Clock and reset
   input  wire logic              i_ref_clk,
   input  wire logic              i_rst_b,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [APB_AW-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Measurement path
   input  wire logic              i_sample_valid,
   input  wire logic [W-1:0]      i_sample,
   input  wire logic [W-1:0]      i_head_temp,
   // Results
   output logic                   o_temp_valid,
   output logic      [W-1:0]      o_processed_temperature,
   output logic      [W-1:0]      o_averaged_temperature,
   output logic      [W-1:0]      o_ambient_temperature
);
   localparam int OW = W + 1;

   if (W < 8 || W > 32) begin : g_chk_w
      $error("Temperature width must be 8 to 32 bits");
   end
   if (TICK_CYC < 2) begin : g_chk_tick
      $error("Tick period must be at least 2 cycles");
   end
   if (PIPE_LATENCY > DETECT_CYC) begin : g_chk_lat
      $error("Pipeline latency exceeds hotspot detection time");
   end

   // Flip sign for minimum modes so one peak engine serves both
   function automatic logic signed [OW-1:0] orient(input logic [W-1:0] v,
                                                   input logic inv);
      logic signed [OW-1:0] e;
      e = OW'(signed'(v));
      return inv ? -e : e;
   endfunction

   function automatic hold_mode_e decode_mode(input logic [CTRL_MODE_W-1:0] v);
      case (v)
         3'h1:    return MAXIMUM_HOLD_MODE;
         3'h2:    return MINIMUM_HOLD_MODE;
         3'h3:    return ADVANCED_MAXIMUM_HOLD_MODE;
         3'h4:    return ADVANCED_MINIMUM_HOLD_MODE;
         default: return HOLD_NONE;
      endcase
   endfunction

   // Registers
   logic [4:0]   ctrl_q;
   logic [15:0]  avg_ms_q;
   logic [6:0]   hold_dur_q;
   logic [W-1:0] thresh_q;
   logic [W-1:0] hyst_q;
   logic [W-1:0] ambient_q;

   wire        acc_ok = psel & penable;
   wire        wr     = acc_ok & pwrite;
   wire [31:0] wd     = pwdata;
   wire        mapped = (paddr == ADDR_CTRL)     || (paddr == ADDR_AVG_TIME) ||
                        (paddr == ADDR_HOLD_DUR) || (paddr == ADDR_THRESH)   ||
                        (paddr == ADDR_HYST)     || (paddr == ADDR_AMBIENT)  ||
                        (paddr == ADDR_STATUS)   || (paddr == ADDR_PROC)     ||
                        (paddr == ADDR_AVG);

   assign pready  = 1'b1;
   assign pslverr = acc_ok & ~mapped;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl_q     <= CTRL_RST;
         avg_ms_q   <= AVG_TIME_RST;
         hold_dur_q <= HOLD_DUR_RST;
         thresh_q   <= THRESH_RST;
         hyst_q     <= HYST_RST;
         ambient_q  <= AMBIENT_RST;
      end else if (wr) begin
         case (paddr)
            ADDR_CTRL:     ctrl_q    <= wd[4:0];
            ADDR_AVG_TIME: avg_ms_q  <= wd[15:0];
            ADDR_HOLD_DUR: hold_dur_q <= (wd[6:0] > HOLD_INFINITE) ? HOLD_INFINITE
                                                                   : wd[6:0];
            ADDR_THRESH:   thresh_q  <= wd[W-1:0];
            ADDR_HYST:     hyst_q    <= wd[W-1:0];
            ADDR_AMBIENT:  ambient_q <= wd[W-1:0];
            default:       ;
         endcase
      end
   end

   // Mode decode
   wire hold_mode_e mode   = decode_mode(ctrl_q[CTRL_MODE_LSB +: CTRL_MODE_W]);
   wire             hyst_en = ctrl_q[CTRL_HYST_BIT];
   wire             use_fix = ctrl_q[CTRL_FIXED_BIT];
   wire             inv     = (mode == MINIMUM_HOLD_MODE) ||
                              (mode == ADVANCED_MINIMUM_HOLD_MODE);
   wire             simple  = (mode == MAXIMUM_HOLD_MODE) ||
                              (mode == MINIMUM_HOLD_MODE);
   wire             adv     = (mode == ADVANCED_MAXIMUM_HOLD_MODE) ||
                              (mode == ADVANCED_MINIMUM_HOLD_MODE);

   // Ambient compensation source
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_ambient_temperature <= '0;
      end else begin
         o_ambient_temperature <= use_fix ? ambient_q : i_head_temp;
      end
   end

   // Averaging stage and ms tick
   sample_if #(.W(W)) avg_bus ();
   logic ms_tick;

   tick_gen #(.TICK_CYC(TICK_CYC)) u_tick (
      .i_ref_clk (i_ref_clk),
      .i_rst_b   (i_rst_b),
      .o_tick    (ms_tick)
   );

   avg_filter #(.W(W), .SAMPLE_SHIFT(SAMPLE_SHIFT)) u_avg (
      .i_ref_clk (i_ref_clk),
      .i_rst_b   (i_rst_b),
      .i_valid   (i_sample_valid),
      .i_sample  (i_sample),
      .i_avg_ms  (avg_ms_q),
      .out       (avg_bus.src)
   );

   // Hold stage state
   hold_state_e          st_q;
   hold_mode_e           mode_prev_q;
   logic signed [OW-1:0] held_q;
   logic signed [OW-1:0] min_q;
   logic signed [OW-1:0] cand_q;
   logic                 armed_q;
   logic [9:0]           ms_cnt_q;
   logic [6:0]           sec_cnt_q;

   wire signed [OW-1:0] x     = orient(avg_bus.data, inv);
   wire signed [OW-1:0] thr   = orient(thresh_q, inv);
   wire signed [OW-1:0] hyst  = OW'(hyst_q);
   wire                 fresh = (mode != mode_prev_q);
   wire                 hold_en = simple && (hold_dur_q != HOLD_OFF_VAL);
   wire                 expire  = (hold_dur_q != HOLD_INFINITE) &&
                                  (sec_cnt_q >= hold_dur_q);
   wire signed [OW-1:0] gap     = held_q - min_q;
   wire signed [OW-1:0] stepped = held_q - (gap >>> STEP_SHIFT);
   wire signed [OW-1:0] decayed = held_q - ((held_q - x) >>> DECAY_SHIFT);
   wire signed [OW-1:0] cand_n  = (x > cand_q) ? x : cand_q;
   wire                 passed  = hyst_en ? (x <= cand_n - hyst)
                                          : (x < cand_n);
   wire                 allowed = (cand_n >= held_q) || armed_q;
   wire                 below   = (x < thr);
   wire signed [OW-1:0] out_o   = inv ? -held_q : held_q;

   // Hold timer in ms and seconds
   wire timer_run = (st_q == ST_HOLD_FIRST) || (st_q == ST_HOLD_SECOND);
   wire restart   = avg_bus.valid && (x > held_q || (timer_run && expire));

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ms_cnt_q  <= '0;
         sec_cnt_q <= '0;
      end else if (!timer_run || restart) begin
         ms_cnt_q  <= '0;
         sec_cnt_q <= '0;
      end else if (ms_tick) begin
         ms_cnt_q  <= (ms_cnt_q == 10'(MS_PER_S - 1)) ? '0 : ms_cnt_q + 1'b1;
         if (ms_cnt_q == 10'(MS_PER_S - 1) && sec_cnt_q != 7'h7F) begin
            sec_cnt_q <= sec_cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_q        <= ST_TRACK;
         mode_prev_q <= HOLD_NONE;
         held_q      <= '0;
         min_q       <= '0;
         cand_q      <= '0;
         armed_q     <= 1'b0;
      end else if (avg_bus.valid) begin
         mode_prev_q <= mode;
         if (fresh || !(hold_en || adv)) begin
            st_q    <= ST_TRACK;
            held_q  <= x;
            min_q   <= x;
            cand_q  <= x;
            armed_q <= 1'b0;
         end else if (adv) begin
            if (below) begin
               armed_q <= 1'b1;
            end
            if (passed && allowed) begin
               held_q  <= cand_n;
               cand_q  <= x;
               armed_q <= below;
            end else if (passed) begin
               cand_q  <= x;
            end else begin
               cand_q  <= cand_n;
            end
         end else begin
            case (st_q)
               ST_TRACK: begin
                  if (x >= held_q) begin
                     held_q <= x;
                  end else begin
                     st_q  <= ST_HOLD_FIRST;
                     min_q <= x;
                  end
               end
               ST_HOLD_FIRST, ST_HOLD_SECOND: begin
                  if (x > held_q) begin
                     held_q <= x;
                     min_q  <= x;
                     st_q   <= ST_HOLD_FIRST;
                  end else if (expire) begin
                     if (st_q == ST_HOLD_FIRST) begin
                        held_q <= stepped;
                        min_q  <= x;
                        st_q   <= ST_HOLD_SECOND;
                     end else begin
                        st_q <= ST_DECAY;
                     end
                  end else if (x < min_q) begin
                     min_q <= x;
                  end
               end
               ST_DECAY: begin
                  if (x >= decayed) begin
                     held_q <= x;
                     st_q   <= ST_TRACK;
                  end else begin
                     held_q <= decayed;
                  end
               end
               default: st_q <= ST_TRACK;
            endcase
         end
      end
   end

   // Output register; processed follows averaged when no hold runs
   logic out_pend_q;
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         out_pend_q              <= 1'b0;
         o_temp_valid            <= 1'b0;
         o_averaged_temperature  <= '0;
         o_processed_temperature <= '0;
      end else begin
         out_pend_q   <= avg_bus.valid;
         o_temp_valid <= out_pend_q;
         if (avg_bus.valid) begin
            o_averaged_temperature <= avg_bus.data;
         end
         if (out_pend_q) begin
            o_processed_temperature <= out_o[W-1:0];
         end
      end
   end

   // Register read mux
   wire [31:0] status_word = {24'h00_0000, 1'b0, armed_q, st_q, 1'b0, ctrl_q[2:0]};
   always_comb begin
      prdata = 32'h0000_0000;
      if (acc_ok && !pwrite) begin
         case (paddr)
            ADDR_CTRL:     prdata = {27'h000_0000, ctrl_q};
            ADDR_AVG_TIME: prdata = {16'h0000, avg_ms_q};
            ADDR_HOLD_DUR: prdata = {25'h000_0000, hold_dur_q};
            ADDR_THRESH:   prdata = 32'(thresh_q);
            ADDR_HYST:     prdata = 32'(hyst_q);
            ADDR_AMBIENT:  prdata = 32'(ambient_q);
            ADDR_STATUS:   prdata = status_word;
            ADDR_PROC:     prdata = 32'(o_processed_temperature);
            ADDR_AVG:      prdata = 32'(o_averaged_temperature);
            default:       prdata = 32'h0000_0000;
         endcase
      end
   end
endmodule // temp_post_proc

// *** src/tick_gen.sv ***
// Millisecond tick generator
`timescale 1ns/1ns
module tick_gen #(
   parameter int TICK_CYC = 10000
) (
   input  wire logic i_ref_clk,
   input  wire logic i_rst_b,
   output logic      o_tick
);
   localparam int CW = $clog2(TICK_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(TICK_CYC - 1);

   logic [CW-1:0] cnt_q;
   wire           wrap = (cnt_q == LAST);

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_q  <= '0;
         o_tick <= 1'b0;
      end else begin
         cnt_q  <= wrap ? '0 : cnt_q + 1'b1;
         o_tick <= wrap;
      end
   end
endmodule // tick_gen

// *** src/tpp_pkg.sv ***
// Constants, register map and types of the temperature post-processing block
package tpp_pkg;
   // Data widths
   localparam int TEMP_W = 16;
   localparam int APB_AW = 8;

   // Register byte offsets
   localparam logic [APB_AW-1:0] ADDR_CTRL     = 8'h00;
   localparam logic [APB_AW-1:0] ADDR_AVG_TIME = 8'h04;
   localparam logic [APB_AW-1:0] ADDR_HOLD_DUR = 8'h08;
   localparam logic [APB_AW-1:0] ADDR_THRESH   = 8'h0C;
   localparam logic [APB_AW-1:0] ADDR_HYST     = 8'h10;
   localparam logic [APB_AW-1:0] ADDR_AMBIENT  = 8'h14;
   localparam logic [APB_AW-1:0] ADDR_STATUS   = 8'h18;
   localparam logic [APB_AW-1:0] ADDR_PROC     = 8'h1C;
   localparam logic [APB_AW-1:0] ADDR_AVG      = 8'h20;

   // Control register fields
   localparam int CTRL_MODE_LSB  = 0;
   localparam int CTRL_MODE_W    = 3;
   localparam int CTRL_HYST_BIT  = 3;
   localparam int CTRL_FIXED_BIT = 4;

   // Reset values
   localparam logic [4:0]        CTRL_RST     = 5'h00;
   localparam logic [15:0]       AVG_TIME_RST = 16'h0014;
   localparam logic [6:0]        HOLD_DUR_RST = 7'h01;
   localparam logic [TEMP_W-1:0] THRESH_RST   = 16'h0000;
   localparam logic [TEMP_W-1:0] HYST_RST     = 16'h0000;
   localparam logic [TEMP_W-1:0] AMBIENT_RST  = 16'h0000;

   // Hold duration limits in seconds
   localparam logic [6:0] HOLD_INFINITE = 7'h41;
   localparam logic [6:0] HOLD_OFF_VAL  = 7'h00;

   // Expiry step of one eighth and decay speed
   localparam int STEP_SHIFT  = 3;
   localparam int DECAY_SHIFT = 4;

   // Timing
   localparam int CLK_PERIOD_NS  = 100;
   localparam int AVG_STEP_MS    = 1;
   localparam int MS_TICK_CYC    = AVG_STEP_MS * 1000000 / CLK_PERIOD_NS;
   localparam int MS_PER_S       = 1000;
   localparam int DETECT_TIME_US = 90;
   localparam int DETECT_CYC     = DETECT_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int PIPE_LATENCY   = 3;

   typedef enum logic [2:0] {
      HOLD_NONE,
      MAXIMUM_HOLD_MODE,
      MINIMUM_HOLD_MODE,
      ADVANCED_MAXIMUM_HOLD_MODE,
      ADVANCED_MINIMUM_HOLD_MODE
   } hold_mode_e;

   typedef enum logic [1:0] {
      ST_TRACK,
      ST_HOLD_FIRST,
      ST_HOLD_SECOND,
      ST_DECAY
   } hold_state_e;
endpackage

// *** test/meas_path_model.sv ***
// Measurement path model: sample strobe and head probe level
`timescale 1ns/1ns
module meas_path_model (
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_b,
   // Requests from the bench
   input  wire logic        i_req,
   input  wire logic [15:0] i_value,
   input  wire logic [15:0] i_head,
   // Toward the block
   output logic             o_valid,
   output logic      [15:0] o_sample,
   output logic      [15:0] o_head_temp
);
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_valid     <= 1'b0;
         o_sample    <= 16'h0000;
         o_head_temp <= 16'h0000;
      end else begin
         o_valid     <= i_req;
         // Sample line flips every cycle between strobes, alternating between the inverse of the last value and the value itself
         o_sample    <= i_req ? i_value : ~o_sample;
         o_head_temp <= i_head;
      end
   end
endmodule // meas_path_model

// *** test/testbench.sv ***
// Self-checking bench of the temperature post-processing top
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin mismatches++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module testbench import tpp_pkg::*;;
   localparam int TICK = 2;
   localparam int SEC  = MS_PER_S * TICK;
   logic        i_ref_clk = 1'b0;
   logic        i_rst_b   = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, req, s_valid, t_valid, errv;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [15:0] val, head, s_data, head_temp, proc, avgd, amb;
   int          tests_run, mismatches;
   logic [7:0]  rst_addr [6] = '{ADDR_CTRL, ADDR_AVG_TIME, ADDR_HOLD_DUR, ADDR_THRESH,
                                 ADDR_HYST, ADDR_AMBIENT};
   logic [31:0] rst_val [6] = '{32'(CTRL_RST), 32'(AVG_TIME_RST), 32'(HOLD_DUR_RST),
                                32'(THRESH_RST), 32'(HYST_RST), 32'(AMBIENT_RST)};

   always #(CLK_PERIOD_NS / 2) i_ref_clk = ~i_ref_clk;

   meas_path_model u_meas (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_req(req),
      .i_value(val), .i_head(head), .o_valid(s_valid), .o_sample(s_data),
      .o_head_temp(head_temp));
   temp_post_proc #(.TICK_CYC(TICK)) dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .i_sample_valid(s_valid),
      .i_sample(s_data), .i_head_temp(head_temp), .o_temp_valid(t_valid),
      .o_processed_temperature(proc), .o_averaged_temperature(avgd),
      .o_ambient_temperature(amb));

   task automatic stop_test;
      $display("Checks run %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge i_ref_clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge i_ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rdv  = prdata;
      errv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         mismatches++;
         stop_test();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(nm, ex, rdv)
   endtask

   task automatic send(input logic [15:0] v);
      int n;
      @(posedge i_ref_clk);
      req <= 1'b1;
      val <= v;
      @(posedge i_ref_clk);
      req <= 1'b0;
      n = 0;
      while (t_valid !== 1'b1 && n < 20) begin
         @(posedge i_ref_clk);
         n++;
      end
      if (n >= 20) begin
         mismatches++;
         stop_test();
      end
      `CHK("detect time", 1'b1, n < DETECT_CYC)
   endtask

   task automatic run(input int cyc, input logic [15:0] v);
      repeat (cyc / 100) begin
         send(v);
         repeat (94) @(posedge i_ref_clk);
      end
   endtask

   task automatic pc(input string nm, input logic [15:0] ex);
      `CHK(nm, ex, proc)
   endtask

   task automatic adv(input logic [2:0] md, input int sg);
      wr(ADDR_CTRL, 32'h0000_0000);
      send(16'h0000);
      wr(ADDR_THRESH, {16'h0000, 16'(sg * 300)});
      wr(ADDR_HYST, 32'h0000_0064);
      wr(ADDR_CTRL, {28'h000_0000, 1'b1, md});
      send(16'(sg * 500));
      send(16'(sg * 400));
      pc("adv first", 16'(sg * 500));
      send(16'(sg * 700));
      send(16'(sg * 650));
      pc("adv inside hyst", 16'(sg * 500));
      send(16'(sg * 590));
      pc("adv past hyst", 16'(sg * 700));
      send(16'(sg * 690));
      send(16'(sg * 580));
      pc("adv unarmed", 16'(sg * 700));
      send(16'(sg * 250));
      send(16'(sg * 400));
      send(16'(sg * 290));
      `CHK("adv armed", 1'b1, sg * $signed(proc) < 700)
   endtask

   initial begin
      {psel, penable, pwrite, req} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      val = 16'h0000;
      head = 16'h0123;
      tests_run = 0;
      mismatches = 0;
      repeat (5) @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      foreach (rst_addr[i]) rdc("reset value", rst_addr[i], rst_val[i]);
      apb(1'b0, 8'h24, 32'h0000_0000);
      `CHK("unmapped err", 1'b1, errv)
      `CHK("unmapped data", 32'h0000_0000, rdv)
      wr(ADDR_HOLD_DUR, 32'h0000_0064);
      rdc("hold clamp", ADDR_HOLD_DUR, 32'(HOLD_INFINITE));
      for (int i = 0; i < 5; i++) begin
         wr(ADDR_CTRL, 32'(i));
         apb(1'b0, ADDR_STATUS, 32'h0000_0000);
         `CHK("status mode", 3'(i), rdv[2:0])
      end
      wr(ADDR_CTRL, 32'h0000_0000);
      `CHK("ambient head", 16'h0123, amb)
      wr(ADDR_AMBIENT, 32'h0000_0456);
      wr(ADDR_CTRL, 32'h0000_0010);
      repeat (2) @(posedge i_ref_clk);
      `CHK("ambient fixed", 16'h0456, amb)
      wr(ADDR_CTRL, 32'h0000_0000);
      wr(ADDR_AVG_TIME, 32'h0000_0000);
      wr(ADDR_HOLD_DUR, 32'h0000_0001);
      send(16'h1234);
      pc("hold off", 16'h1234);
      rdc("processed reg", ADDR_PROC, 32'h0000_1234);
      send(16'hFFFB);
      rdc("averaged reg", ADDR_AVG, 32'h0000_FFFB);
      send(16'h0000);
      wr(ADDR_AVG_TIME, 32'h0000_0001);
      wr(ADDR_CTRL, 32'h0000_0001);
      send(16'h00A0);
      `CHK("average", 16'h000A, avgd)
      pc("average into hold", 16'h000A);
      wr(ADDR_AVG_TIME, 32'h0000_0000);
      wr(ADDR_CTRL, 32'h0000_0000);
      wr(ADDR_CTRL, 32'h0000_0001);
      send(16'd1000);
      send(16'd200);
      pc("peak held", 16'd1000);
      run(SEC * 8 / 10, 16'd200);
      pc("peak still held", 16'd1000);
      run(SEC * 4 / 10, 16'd200);
      pc("peak step", 16'd900);
      run(SEC * 7 / 10, 16'd200);
      pc("peak step held", 16'd900);
      run(SEC * 6 / 10, 16'd200);
      `CHK("peak decay", 1'b1, proc < 16'd900 && proc > 16'd200)
      wr(ADDR_CTRL, 32'h0000_0000);
      wr(ADDR_HOLD_DUR, 32'h0000_0041);
      wr(ADDR_CTRL, 32'h0000_0001);
      send(16'd1000);
      send(16'd200);
      run(SEC * 14 / 10, 16'd200);
      pc("hold forever", 16'd1000);
      wr(ADDR_CTRL, 32'h0000_0000);
      wr(ADDR_HOLD_DUR, 32'h0000_0000);
      wr(ADDR_CTRL, 32'h0000_0001);
      send(16'd1000);
      send(16'd200);
      pc("hold disabled", 16'd200);
      wr(ADDR_CTRL, 32'h0000_0000);
      wr(ADDR_HOLD_DUR, 32'h0000_0001);
      wr(ADDR_CTRL, 32'h0000_0002);
      send(16'd0);
      send(16'd800);
      pc("valley held", 16'd0);
      run(SEC * 12 / 10, 16'd800);
      pc("valley step", 16'd100);
      adv(3'h3, 1);
      adv(3'h4, -1);
      wr(ADDR_CTRL, 32'h0000_0003);
      send(16'd500);
      send(16'd600);
      send(16'd550);
      pc("adv no hyst", 16'd600);
      stop_test();
   end
endmodule // testbench

// *** test/tpp_assertions.sv ***
// Port-level checker of the temperature post-processing top
`timescale 1ns/1ns
module tpp_assertions import tpp_pkg::*; #(
   parameter int W = TEMP_W
) (
   // Clock and reset
   input wire logic              i_ref_clk,
   input wire logic              i_rst_b,
   // APB slave
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // Measurement path
   input wire logic              i_sample_valid,
   input wire logic [W-1:0]      i_sample,
   input wire logic [W-1:0]      i_head_temp,
   // Results
   input wire logic              o_temp_valid,
   input wire logic [W-1:0]      o_processed_temperature,
   input wire logic [W-1:0]      o_averaged_temperature,
   input wire logic [W-1:0]      o_ambient_temperature
);
   // Shadow of the control and ambient settings
   wire        wr_en = psel && penable && pwrite;
   logic [2:0] mode_q;
   logic       fixed_q;
   logic [W-1:0] amb_q;
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mode_q  <= 3'h0;
         fixed_q <= 1'b0;
         amb_q   <= '0;
      end else if (wr_en && paddr == ADDR_CTRL) begin
         mode_q  <= pwdata[2:0];
         fixed_q <= pwdata[CTRL_FIXED_BIT];
      end else if (wr_en && paddr == ADDR_AMBIENT) begin
         amb_q <= pwdata[W-1:0];
      end
   end
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
   ready_high_a: assert property (pready) else $error("pready low");
   valid_latency_a: assert property (i_sample_valid |-> ##3 o_temp_valid)
      else $error("result strobe late");
   valid_cause_a: assert property (o_temp_valid |-> $past(i_sample_valid, 3))
      else $error("result strobe without sample");
   avg_cause_a: assert property (
      $changed(o_averaged_temperature) |-> $past(i_sample_valid, 2))
      else $error("average moved without sample");
   proc_cause_a: assert property ($changed(o_processed_temperature) |-> o_temp_valid)
      else $error("processed moved without strobe");
   unmapped_err_a: assert property (psel && penable && paddr > ADDR_AVG |-> pslverr && prdata == 0)
      else $error("unmapped access not refused");
   idle_rdata_a: assert property (!(psel && penable) |-> prdata == 32'h0000_0000)
      else $error("read data outside access");
   hold_off_a: assert property (o_temp_valid && mode_q == 3'h0 |->
      o_processed_temperature == $past(o_averaged_temperature)) else $error("hold off differs");
   ambient_head_a: assert property (!fixed_q |=> o_ambient_temperature == $past(i_head_temp))
      else $error("ambient not head probe");
   ambient_fixed_a: assert property (fixed_q |=> o_ambient_temperature == $past(amb_q))
      else $error("ambient not fixed value");
   cover property (o_temp_valid && mode_q == 3'h1);
   cover property (psel && penable && pslverr);
   cover property (fixed_q && o_temp_valid);
endmodule // tpp_assertions

bind temp_post_proc tpp_assertions #(.W(W)) u_tpp_chk (
   .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .i_sample_valid(i_sample_valid), .i_sample(i_sample),
   .i_head_temp(i_head_temp), .o_temp_valid(o_temp_valid),
   .o_processed_temperature(o_processed_temperature),
   .o_averaged_temperature(o_averaged_temperature),
   .o_ambient_temperature(o_ambient_temperature));
